/* snv_fifo.v */
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: single clock, asynchronous active-low reset
// Notes:   depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module snv_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,      // Clock
  input  wire             arst_n,   // Async reset
  input  wire             flush,    // Drop contents
  input  wire [WIDTH-1:0] in_data,  // Fill data
  input  wire             in_valid, // Fill valid
  output wire             in_ready, // Not full
  output wire [WIDTH-1:0] out_data, // Head word
  output wire             out_valid,// Not empty
  input  wire             out_ready // Drain strobe
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wp;
  reg [AW:0]      rp;
  wire            full  = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  wire            empty = (wp == rp);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp[AW-1:0]];
  // Pointers with one wrap bit for honest full/empty
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp <= {(AW+1){1'b0}};
      rp <= {(AW+1){1'b0}};
    end else if (flush) begin
      wp <= {(AW+1){1'b0}};
      rp <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full)
        wp <= wp + 1'b1;
      if (out_ready && !empty)
        rp <= rp + 1'b1;
    end
  end
  // Storage has no reset, only data
  always @(posedge clk) begin
    if (in_valid && !full && !flush)
      mem[wp[AW-1:0]] <= in_data;
  end
endmodule // snv_fifo
`default_nettype wire

/* snv_master_model.sv */
// Purpose: SPI master facing the memory slave
// Assumes: mode 0 or 3 by cpol, 160 ns serial clock
// Notes:   released SO reads as the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module snv_master_model (
  input  wire logic MCLK,  // Bench clock
  input  wire logic SO,    // Slave out
  input  wire logic SO_OE, // Slave enable
  output var  logic CS_N,  // Select
  output var  logic SCK,   // Serial clock
  output var  logic SI,    // Serial in
  output var  logic HOLD_N // Hold
);
  logic cpol; // SCK idle level
  logic last; // Last driven SO
  logic sow;  // SO as seen
  initial begin
    cpol   = 1'b0;
    CS_N   = 1'b1;
    SCK    = 1'b0;
    SI     = 1'b0;
    HOLD_N = 1'b1;
    last   = 1'b0;
  end
  // Float shows the inverse so a stale bit never matches
  always @(posedge MCLK) if (SO_OE) last <= SO;
  assign sow = SO_OE ? SO : ~last;
  task automatic half();
    repeat (10) @(negedge MCLK);
  endtask
  // Fresh select per opcode
  task automatic sel();
    SCK = cpol;
    half();
    CS_N = 1'b0;
    half();
  endtask
  task automatic desel();
    half();
    SCK = cpol;
    half();
    CS_N = 1'b1;
    SI   = ~SI;
    half();
  endtask
  // Byte MSB first, taken at SCK rise; hold pulses SCK to prove it ignored
  task automatic xb(input logic [7:0] tx, input logic hd, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      SCK = 1'b0;
      SI  = tx[i];
      half();
      if (hd && i == 4) begin
        HOLD_N = 1'b0;
        half();
        SCK = 1'b1;
        half();
        SCK = 1'b0;
        half();
        HOLD_N = 1'b1;
        half();
      end
      SCK   = 1'b1;
      rx[i] = sow;
      half();
    end
  endtask
endmodule // snv_master_model
`default_nettype wire

/* snv_regs.vh */
// Purpose: constants for the serial nonvolatile RAM slave
// Assumes: standard serial memory command set
// Notes:   opcodes and status bit positions are plain defaults
`ifndef SNV_REGS_VH
`define SNV_REGS_VH
`define SNV_OP_SET_WEL   8'h06
`define SNV_OP_CLR_WEL   8'h04
`define SNV_OP_RD_STAT   8'h05
`define SNV_OP_WR_STAT   8'h01
`define SNV_OP_READ      8'h03
`define SNV_OP_WRITE     8'h02
`define SNV_SR_WEL       1
`define SNV_SR_BP_LO     2
`define SNV_SR_BP_HI     3
`define SNV_SR_GUARD     7
`define SNV_SR_WMASK     8'h8C
`define SNV_SR_RESET     8'h00
`define SNV_ADDR_BITS    13
`define SNV_BIT_LAST     3'h7
`define SNV_SCK_MAX_HZ   20000000
`define SNV_BP_NONE      2'h0
`define SNV_BP_QUARTER   2'h1
`define SNV_BP_HALF      2'h2
`endif

/* snv_spi_nvram.v */
// Purpose: SPI slave front end of an 8K x 8 byte memory
// Assumes: MCLK much faster than SCK; pins oversampled through three flops
// Notes:   accepted write data bytes queue in a FIFO before commit to the array
// Behaviour
// - Low chip select selects the device and enables serial clock use.
// - High chip select: standby, inputs ignored, serial output released.
// - Input sampled on SCK rise; output changes on SCK fall.
// - SCK from zero to 20 MHz, may stop anywhere; logic is static.
// - Output driven only with read data, never while hold is low.
// - Guard bit set and protect pin low refuse status writes.
// - Hold low suspends operation, ignoring SCK edges; a chip select rise still deselects and ends the frame.
// - Clock modes 0 and 3 work; others are unsupported.
// - Each byte commits once its eighth bit arrives, no busy time.
// - Array holds 8K individually addressed bytes.
// - Block protection guards upper quarter, upper half or whole array, but bytes after a wrap commit from the first guarded address.
// - Write-disable clears write enable; later writes are rejected.
// - Two-byte address, MSB first, low 13 bits used.
// - First byte after select is the opcode; one per selection.
// - Unknown opcode: ignore the rest of the frame, output stays released.
// - All bytes move most significant bit first.
`timescale 1ns/1ps
`default_nettype none
`include "snv_regs.vh"
module snv_spi_nvram #(
  parameter DEPTH  = 8192,
  parameter FDEPTH = 32,
  parameter FAW    = 5
) (
  input  wire MCLK,     // System clock, 125 MHz
  input  wire ARST_N,   // Async reset, active low
  input  wire CS_N,     // Chip select pin
  input  wire SCK,      // Serial clock pin
  input  wire SI,       // Serial data in
  input  wire HOLD_N,   // Hold pin
  input  wire WP_N,     // Write-protect pin
  output reg  SO,       // Serial data out
  output reg  SO_OE     // Serial output enable
);
  localparam CLK_HZ   = 125000000;
  localparam SCK_MIN  = CLK_HZ / `SNV_SCK_MAX_HZ; // cycles per SCK period
  localparam S_OPC    = 3'h0;
  localparam S_ADDR_H = 3'h1;
  localparam S_ADDR_L = 3'h2;
  localparam S_DATA   = 3'h3;
  localparam S_STAT   = 3'h4;
  localparam S_IGNORE = 3'h5;
  localparam S_DONE   = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three flops; select, SCK and hold changes count when stages two and three agree, SI and protect taken from stage three
  reg [2:0] cs_s;
  reg [2:0] sck_s;
  reg [2:0] si_s;
  reg [2:0] hold_s;
  reg [2:0] wp_s;
  reg       cs_f;
  reg       sck_f;
  reg       hold_f;
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cs_s   <= 3'h7;
      sck_s  <= 3'h0;
      si_s   <= 3'h0;
      hold_s <= 3'h7;
      wp_s   <= 3'h7;
      cs_f   <= 1'b1;
      sck_f  <= 1'b0;
      hold_f <= 1'b1;
    end else begin
      cs_s   <= {cs_s[1:0], CS_N};
      sck_s  <= {sck_s[1:0], SCK};
      si_s   <= {si_s[1:0], SI};
      hold_s <= {hold_s[1:0], HOLD_N};
      wp_s   <= {wp_s[1:0], WP_N};
      if (cs_s[1] == cs_s[2])
        cs_f <= cs_s[2];
      if (sck_s[1] == sck_s[2])
        sck_f <= sck_s[2];
      if (hold_s[1] == hold_s[2])
        hold_f <= hold_s[2];
    end
  end
  wire si_q  = si_s[2];
  wire wp_q  = wp_s[2];
  // Hold gates the SCK and chip-select edge strobes; sel still follows chip select
  wire run   = hold_f && (hold_s[1] == hold_s[2]) && hold_s[2];
  wire sck_n = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_f;
  wire cs_n  = (cs_s[1] == cs_s[2]) ? cs_s[2] : cs_f;
  wire sel   = !cs_f;
  wire rise  = run && sel && !sck_f && sck_n;
  wire fall  = run && sel && sck_f && !sck_n;
  wire start = run && cs_f && !cs_n;
  wire stop  = run && !cs_f && cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode decode, used for unknown-opcode rejection and state steering
  function known_op;
    input [7:0] op;
    begin
      known_op = (op == `SNV_OP_SET_WEL) || (op == `SNV_OP_CLR_WEL) ||
                 (op == `SNV_OP_RD_STAT) || (op == `SNV_OP_WR_STAT) ||
                 (op == `SNV_OP_READ)    || (op == `SNV_OP_WRITE);
    end
  endfunction
  // Block protection decode for one address
  function guarded;
    input [1:0]                bp;
    input [`SNV_ADDR_BITS-1:0] a;
    begin
      case (bp)
        `SNV_BP_NONE:    guarded = 1'b0;
        `SNV_BP_QUARTER: guarded = (a[`SNV_ADDR_BITS-1:`SNV_ADDR_BITS-2] == 2'h3);
        `SNV_BP_HALF:    guarded = a[`SNV_ADDR_BITS-1];
        default:         guarded = 1'b1;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frame state
  reg [2:0]                state;
  reg [2:0]                bitc;
  reg [7:0]                shin;
  reg [7:0]                opc;
  reg [`SNV_ADDR_BITS-1:0] addr;
  reg [7:0]                shout;
  reg                      out_on;
  reg [7:0]                stat;
  reg [`SNV_ADDR_BITS-1:0] wr_addr;
  reg [7:0]                mem [0:DEPTH-1];
  wire [7:0] byte_in = {shin[6:0], si_q};
  wire       last    = rise && (bitc == `SNV_BIT_LAST);
  wire [1:0] bp      = stat[`SNV_SR_BP_HI:`SNV_SR_BP_LO];
  wire       wel     = stat[`SNV_SR_WEL];
  wire       sr_lock = stat[`SNV_SR_GUARD] && !wp_q;

  // Write byte queue between the shifter and the array
  wire                     q_ready;
  wire [7:0]               q_data;
  wire                     q_valid;
  wire                     q_push = last && (state == S_DATA) && (opc == `SNV_OP_WRITE) &&
                                    wel && !guarded(bp, addr);
  // Address pointer of the committing bytes runs alongside the queue
  reg  [`SNV_ADDR_BITS-1:0] q_addr;

  snv_fifo #(.WIDTH(8), .DEPTH(FDEPTH), .AW(FAW)) u_fifo (
    .clk       (MCLK),
    .arst_n    (ARST_N),
    .flush     (1'b0),
    .in_data   (byte_in),
    .in_valid  (q_push),
    .in_ready  (q_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (1'b1)
  );

  // Shifter and command sequencer; fully edge-driven so SCK may stop
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= S_OPC;
      bitc  <= 3'h0;
      shin  <= 8'h00;
      opc   <= 8'h00;
      addr  <= {`SNV_ADDR_BITS{1'b0}};
      stat  <= `SNV_SR_RESET;
      q_addr <= {`SNV_ADDR_BITS{1'b0}};
    end else if (start || stop || !sel) begin
      // Fresh frame on every select falling edge
      state <= S_OPC;
      bitc  <= 3'h0;
    end else if (rise) begin
      bitc <= bitc + 3'h1;
      shin <= byte_in;
      if (last) begin
        case (state)
          S_OPC: begin
            opc <= byte_in;
            if (!known_op(byte_in))
              state <= S_IGNORE;
            else if (byte_in == `SNV_OP_SET_WEL) begin
              stat[`SNV_SR_WEL] <= 1'b1;
              state <= S_DONE;
            end else if (byte_in == `SNV_OP_CLR_WEL) begin
              stat[`SNV_SR_WEL] <= 1'b0;
              state <= S_DONE;
            end else if (byte_in == `SNV_OP_RD_STAT || byte_in == `SNV_OP_WR_STAT)
              state <= S_STAT;
            else
              state <= S_ADDR_H;
          end
          S_ADDR_H: begin
            addr[`SNV_ADDR_BITS-1:8] <= byte_in[`SNV_ADDR_BITS-9:0]; // top 3 ignored
            state <= S_ADDR_L;
          end
          S_ADDR_L: begin
            addr[7:0] <= byte_in;
            if (opc == `SNV_OP_WRITE)
              q_addr <= {addr[`SNV_ADDR_BITS-1:8], byte_in};
            state <= S_DATA;
          end
          S_DATA: begin
            addr <= addr + 1'b1;                               // Wraps at array end
          end
          S_STAT: begin
            if (opc == `SNV_OP_WR_STAT && wel && !sr_lock) begin
              stat  <= (byte_in & `SNV_SR_WMASK) | (stat & ~`SNV_SR_WMASK);
              stat[`SNV_SR_WEL] <= 1'b0;
            end
            state <= S_DONE;
          end
          default: state <= state;
        endcase
      end
    end
    // Drain side steps the commit pointer; kept out of reset so reset stays constant-only
    if (ARST_N && q_valid)
      q_addr <= q_addr + 1'b1;
  end

  // Commit a byte on the same edge it leaves the queue, the cycle after it enters
  always @(posedge MCLK) begin
    if (q_valid)
      mem[q_addr] <= q_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shifter: loads on the fall after the last input bit
  wire reading = (opc == `SNV_OP_READ && (state == S_DATA)) ||
                 (opc == `SNV_OP_RD_STAT && (state == S_STAT || state == S_DONE));
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      shout  <= 8'h00;
      out_on <= 1'b0;
      SO     <= 1'b0;
    end else if (!sel || start) begin
      out_on <= 1'b0;
    end else if (fall) begin
      if (bitc == 3'h0 && reading) begin
        out_on <= 1'b1;
        if (opc == `SNV_OP_READ)
          {SO, shout} <= {mem[addr], 1'b0};
        else
          {SO, shout} <= {stat, 1'b0};
      end else if (reading) begin
        SO    <= shout[7];
        shout <= {shout[6:0], 1'b0};
      end else
        out_on <= 1'b0;
    end
  end
  // Enable dropped at once when hold falls
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N)
      SO_OE <= 1'b0;
    else
      SO_OE <= out_on && sel && hold_f && hold_s[2];
  end
  // Queue full cannot occur: MCLK drains one byte per cycle far faster than SCK fills
  wire unused = q_ready | (SCK_MIN == 0);
endmodule // snv_spi_nvram
`default_nettype wire

/* snv_spi_nvram_sva.sv */
// Purpose: pin timing checks on the serial memory slave
// Assumes: MCLK oversamples SCK, CS_N and HOLD_N
// Notes:   sees only the top-level ports
`timescale 1ns/1ps
`default_nettype none
module snv_spi_nvram_sva (
  input wire logic MCLK,   // Clock
  input wire logic ARST_N, // Reset
  input wire logic CS_N,   // Select
  input wire logic SCK,    // Serial clock
  input wire logic SI,     // Serial in
  input wire logic HOLD_N, // Hold
  input wire logic WP_N,   // Protect pin
  input wire logic SO,     // Serial out
  input wire logic SO_OE   // Out enable
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  // Clock high while driving, selected
  sequence s_high;
    (SCK && SO_OE && !CS_N)[*4];
  endsequence
  property p_rel_cs; $rose(CS_N) |-> ##[0:6] !SO_OE; endproperty
  a_rel_cs: assert property (p_rel_cs) else $error("SO_OE kept after deselect");
  property p_hold; $fell(HOLD_N) |-> ##[0:6] !SO_OE; endproperty
  a_hold: assert property (p_hold) else $error("SO_OE kept in hold");
  property p_chg; SO_OE && !CS_N && $changed(SO) |-> !SCK && $past(!SCK, 2); endproperty
  a_chg: assert property (p_chg) else $error("SO moved off falling edge");
  property p_steady; s_high |-> $stable(SO); endproperty
  a_steady: assert property (p_steady) else $error("SO moved with SCK high");
  property p_rise; $rose(SO_OE) |-> !CS_N && HOLD_N && !SCK; endproperty
  a_rise: assert property (p_rise) else $error("SO_OE rose out of place");
  property p_sel; SO_OE |-> $past(!CS_N, 7); endproperty
  a_sel: assert property (p_sel) else $error("SO_OE without select");
  property p_stand; $fell(SO_OE) |-> CS_N || !HOLD_N; endproperty
  a_stand: assert property (p_stand) else $error("SO_OE dropped early");
  property p_rst; $rose(ARST_N) |-> !SO_OE [*3]; endproperty
  a_rst: assert property (p_rst) else $error("SO_OE high after reset");
endmodule // snv_spi_nvram_sva
bind snv_spi_nvram snv_spi_nvram_sva snv_spi_nvram_sva_i (.MCLK(MCLK), .ARST_N(ARST_N), .CS_N(CS_N),
  .SCK(SCK), .SI(SI), .HOLD_N(HOLD_N), .WP_N(WP_N), .SO(SO), .SO_OE(SO_OE));
`default_nettype wire

/* snv_spi_nvram_tb.sv */
// Purpose: self-checking bench for the serial memory slave
// Assumes: master model drives the serial pins
// Notes:   each scenario judges its own results
`timescale 1ns/1ps
`default_nettype none
`include "snv_regs.vh"
module snv_spi_nvram_tb;
  localparam logic [7:0] op_we = `SNV_OP_SET_WEL;
  localparam logic [7:0] op_wd = `SNV_OP_CLR_WEL;
  localparam logic [7:0] op_rs = `SNV_OP_RD_STAT;
  localparam logic [7:0] op_ws = `SNV_OP_WR_STAT;
  localparam logic [7:0] op_rd = `SNV_OP_READ;
  localparam logic [7:0] op_wr = `SNV_OP_WRITE;
  logic       MCLK;    // Clock
  logic       ARST_N;  // Reset
  logic       WP_N;    // Protect pin
  logic       oe_seen; // Enable seen
  logic [7:0] rx [5];  // Returned bytes
  int         errors;
  int         tests_run;
  int         cycles;
  wire        CS_N, SCK, SI, HOLD_N, SO, SO_OE;
  snv_spi_nvram snv_spi_nvram_i (.MCLK(MCLK), .ARST_N(ARST_N), .CS_N(CS_N), .SCK(SCK), .SI(SI),
    .HOLD_N(HOLD_N), .WP_N(WP_N), .SO(SO), .SO_OE(SO_OE));
  snv_master_model snv_master_model_i (.MCLK(MCLK), .SO(SO), .SO_OE(SO_OE), .CS_N(CS_N), .SCK(SCK),
    .SI(SI), .HOLD_N(HOLD_N));
  always #4 MCLK = ~MCLK;
  // Watchdog and enable monitor
  always @(posedge MCLK) begin
    cycles++;
    if (SO_OE === 1'b1) oe_seen <= 1'b1;
    if (cycles == 60000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One frame of n bytes; hd holds inside byte 3
  task automatic fr(input int n, input logic [7:0] b0, b1 = 8'h00, b2 = 8'h00, b3 = 8'h00,
                    b4 = 8'h00, input logic hd = 1'b0);
    logic [7:0] b [5];
    b = '{b0, b1, b2, b3, b4};
    snv_master_model_i.sel();
    for (int k = 0; k < n; k++) snv_master_model_i.xb(b[k], hd && k == 3, rx[k]);
    snv_master_model_i.desel();
  endtask
  task automatic t_rw();
    fr(1, op_we);
    fr(5, op_wr, 8'hFF, 8'hFF, 8'hA5, 8'h3C);
    fr(5, op_rd, 8'h1F, 8'hFF);
    chk(rx[3], 8'hA5);
    chk(rx[4], 8'h3C);
    $display("rw done");
  endtask
  task automatic t_mode3();
    snv_master_model_i.cpol = 1'b1;
    fr(4, op_rd, 8'hE0, 8'h00, 8'h00, 8'h00, 1'b1);
    chk(rx[3], 8'h3C);
    snv_master_model_i.cpol = 1'b0;
    $display("mode3 done");
  endtask
  task automatic t_wrdi();
    fr(1, op_we);
    fr(2, op_rs);
    chk(rx[1], 8'h02);
    fr(1, op_wd);
    fr(2, op_rs);
    chk(rx[1], 8'h00);
    fr(4, op_wr, 8'h1F, 8'hFF, 8'h00);
    fr(4, op_rd, 8'h1F, 8'hFF);
    chk(rx[3], 8'hA5);
    $display("wrdi done");
  endtask
  // Top quarter locked; low write carries a hold
  task automatic t_bp();
    fr(1, op_we);
    fr(2, op_ws, 8'h04);
    fr(2, op_rs);
    chk(rx[1], 8'h04);
    fr(1, op_we);
    fr(4, op_wr, 8'h1F, 8'hFF, 8'h11);
    fr(1, op_we);
    fr(4, op_wr, 8'h00, 8'h00, 8'h77, 8'h00, 1'b1);
    fr(5, op_rd, 8'h1F, 8'hFF);
    chk(rx[3], 8'hA5);
    chk(rx[4], 8'h77);
    $display("bp done");
  endtask
  task automatic t_guard();
    fr(1, op_we);
    fr(2, op_ws, 8'h84);
    WP_N = 1'b0;
    fr(1, op_we);
    fr(2, op_ws, 8'h00);
    fr(2, op_rs);
    chk(rx[1] & 8'hFD, 8'h84);
    WP_N = 1'b1;
    fr(1, op_we);
    fr(2, op_ws, 8'h00);
    fr(2, op_rs);
    chk(rx[1], 8'h00);
    $display("guard done");
  endtask
  task automatic t_bad();
    oe_seen = 1'b0;
    fr(5, 8'hFF, op_rd, 8'h1F, 8'hFF);
    chk({7'h00, oe_seen}, 8'h00);
    $display("bad done");
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    MCLK      = 1'b0;
    ARST_N    = 1'b0;
    WP_N      = 1'b1;
    oe_seen   = 1'b0;
    errors    = 0;
    tests_run = 0;
    cycles    = 0;
    repeat (2) @(negedge MCLK);
    ARST_N = 1'b1;
    repeat (4) @(negedge MCLK);
    t_rw();
    t_mode3();
    t_wrdi();
    t_bp();
    t_guard();
    t_bad();
    tally_and_finish();
  end
endmodule // snv_spi_nvram_tb
`default_nettype wire
